// file: design/input_status_pkg.sv
// package: register map, signal bit positions and carrier types
package input_status_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PINS    = 7;
  localparam int unsigned NUM_SIGNALS = 12;
  localparam int unsigned PIN_SEL_W   = 3;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SYS_WORD_OFFSET   = 8'h00;
  localparam logic [7:0] GP_ALL_OFFSET     = 8'h04;
  localparam logic [7:0] GP_LEVEL_OFFSET   = 8'h08;
  localparam logic [7:0] SIG_LEVEL_OFFSET  = 8'h0C;
  localparam logic [7:0] SIG_ENABLE_OFFSET = 8'h10;
  localparam logic [7:0] GP_SINGLE_BASE    = 8'h20;
  localparam logic [7:0] GP_SINGLE_LAST    = 8'h38;
  localparam logic [7:0] SIG_PIN_BASE      = 8'h40;
  localparam logic [7:0] SIG_PIN_LAST      = 8'h6C;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0]  GP_LEVEL_RESET   = 7'h00;
  localparam logic [11:0] SIG_LEVEL_RESET  = 12'h000;
  localparam logic [11:0] SIG_ENABLE_RESET = 12'h000;
  localparam logic [2:0]  SIG_PIN_RESET    = 3'h0;

  // ---------------------------------------------------------------
  // bit positions in the system signal word
  // ---------------------------------------------------------------
  localparam int unsigned BIT_START            = 0;
  localparam int unsigned BIT_ABORT            = 1;
  localparam int unsigned BIT_POSITIVE_STOP    = 2;
  localparam int unsigned BIT_MOTION_STOP      = 3;
  localparam int unsigned BIT_LIMIT_SWITCH_POS = 4;
  localparam int unsigned BIT_LIMIT_SWITCH_NEG = 5;
  localparam int unsigned BIT_HOME             = 6;
  localparam int unsigned BIT_SENSOR           = 7;
  localparam int unsigned BIT_PAUSE            = 8;
  localparam int unsigned BIT_PAUSE_CLEAR      = 9;
  localparam int unsigned BIT_CURRENT_OFF      = 10;
  localparam int unsigned BIT_ALARM_CLEAR      = 11;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic [11:0] sys_word;
    logic [6:0]  gp_active;
  } status_type;

endpackage

// file: design/input_status_reporting.sv
// input status reporting: system signal word and general purpose flags
//
// Notes on behaviour
// [R1] system signal status is one unsigned 12-bit word, 0 to 4095
// [R2] word bits 0..11: start..alarm_clear in the documented order
// [R3] word is the sum of weights of active signals; inactive add zero
// [R4] general purpose report is separate and excludes assigned pins
// [R5] each input 0..6 readable alone: 1 active, 0 not active
// [R6] a pin assigned to a system signal always reads 0 individually
// [R7] each general purpose input uses its own active level
// [R8] active level 0 normally open, 1 normally closed; default open
// [R9] assigned pins use the signal's active level, not their own
// [R10] reads report live state and have no side effects
`timescale 1ns/100ps

module input_status_reporting
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [6:0]  pin_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic      [11:0] system_signal_word_o,
  output logic      [6:0]  gp_status_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // normally closed inverts the pin: open contact means active
  function automatic logic apply_level(input logic lvl, input logic pin);
    apply_level = pin ^ lvl; // [R8]
  endfunction

  // one word-aligned slot of a register array, shared by both paths
  function automatic logic match_slot(input logic [7:0]  addr,
                                      input logic [7:0]  base,
                                      input int unsigned slot);
    match_slot = (addr == 8'(base + 8'(4 * slot)));
  endfunction

  input_status_pkg::bus_req_type req;
  input_status_pkg::status_type  stat;

  assign req.addr  = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr    = wr_i;
  assign req.rd    = rd_i;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [6:0]  gp_active_level_q;
  logic [6:0]  gp_active_level_d;
  logic [11:0] sig_level_q;
  logic [11:0] sig_level_d;
  logic [11:0] sig_enable_q;
  logic [11:0] sig_enable_d;
  logic [2:0]  sig_pin_q [12];
  logic [2:0]  sig_pin_d [12];

  always_comb
  begin
    gp_active_level_d = gp_active_level_q;
    sig_level_d       = sig_level_q;
    sig_enable_d      = sig_enable_q;
    for (int i = 0; i < 12; i++)
    begin
      sig_pin_d[i] = sig_pin_q[i];
    end
    if (req.wr)
    begin
      case (req.addr)
        input_status_pkg::GP_LEVEL_OFFSET:
          gp_active_level_d = req.wdata[6:0];
        input_status_pkg::SIG_LEVEL_OFFSET:
          sig_level_d = req.wdata[11:0];
        input_status_pkg::SIG_ENABLE_OFFSET:
          sig_enable_d = req.wdata[11:0];
        default:
        begin
          for (int i = 0; i < 12; i++)
          begin
            if (match_slot(req.addr, input_status_pkg::SIG_PIN_BASE, i))
            begin
              sig_pin_d[i] = req.wdata[2:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      gp_active_level_q <= input_status_pkg::GP_LEVEL_RESET; // [R8]
      sig_level_q       <= input_status_pkg::SIG_LEVEL_RESET;
      sig_enable_q      <= input_status_pkg::SIG_ENABLE_RESET;
      for (int i = 0; i < 12; i++)
      begin
        sig_pin_q[i] <= input_status_pkg::SIG_PIN_RESET;
      end
    end
    else
    begin
      gp_active_level_q <= gp_active_level_d;
      sig_level_q       <= sig_level_d;
      sig_enable_q      <= sig_enable_d;
      for (int i = 0; i < 12; i++)
      begin
        sig_pin_q[i] <= sig_pin_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // status evaluation
  // ---------------------------------------------------------------
  // pin numbers 7 select nothing, so an enabled signal on 7 stays idle
  logic [6:0]  pin_assigned;
  logic [11:0] sig_active;
  logic [6:0]  gp_active;

  always_comb
  begin
    pin_assigned = 7'h00;
    sig_active   = 12'h000;
    for (int s = 0; s < 12; s++)
    begin
      if (sig_enable_q[s] && (sig_pin_q[s] < 3'h7))
      begin
        pin_assigned[sig_pin_q[s]] = 1'b1;
        // signal uses its own level, never the pin's gp level [R9]
        sig_active[s] = apply_level(sig_level_q[s],
                                    pin_i[sig_pin_q[s]]); // [R9]
      end
    end
    for (int p = 0; p < 7; p++)
    begin
      // assigned pins are forced inactive in the gp view [R6]
      gp_active[p] = !pin_assigned[p] &&
                     apply_level(gp_active_level_q[p], pin_i[p]); // [R7]
    end
  end

  // each bit carries weight 2**n, so the word is the weighted sum [R3]
  assign stat.sys_word  = sig_active; // [R2]
  assign stat.gp_active = gp_active; // [R4]

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // reads mux live state into rdata_q one cycle later; nothing else changes on a read
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [11:0] sys_word_q;
  logic [11:0] sys_word_d;
  logic [6:0]  gp_q;
  logic [6:0]  gp_d;

  always_comb
  begin
    rdata_d    = 32'h0000_0000;
    sys_word_d = stat.sys_word;
    gp_d       = stat.gp_active;
    if (req.rd) // [R10]
    begin
      case (req.addr)
        input_status_pkg::SYS_WORD_OFFSET:
          rdata_d = {20'h00000, stat.sys_word}; // [R1]
        input_status_pkg::GP_ALL_OFFSET:
          rdata_d = {25'h0, stat.gp_active};
        input_status_pkg::GP_LEVEL_OFFSET:
          rdata_d = {25'h0, gp_active_level_q};
        input_status_pkg::SIG_LEVEL_OFFSET:
          rdata_d = {20'h00000, sig_level_q};
        input_status_pkg::SIG_ENABLE_OFFSET:
          rdata_d = {20'h00000, sig_enable_q};
        default:
        begin
          for (int p = 0; p < 7; p++)
          begin
            if (match_slot(req.addr, input_status_pkg::GP_SINGLE_BASE, p))
            begin
              rdata_d = {31'h0, stat.gp_active[p]}; // [R5]
            end
          end
          for (int s = 0; s < 12; s++)
          begin
            if (match_slot(req.addr, input_status_pkg::SIG_PIN_BASE, s))
            begin
              rdata_d = {29'h0, sig_pin_q[s]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_q    <= 32'h0000_0000;
      sys_word_q <= 12'h000;
      gp_q       <= 7'h00;
    end
    else
    begin
      rdata_q    <= rdata_d;
      sys_word_q <= sys_word_d;
      gp_q       <= gp_d;
    end
  end

  assign rdata_o              = rdata_q;
  assign system_signal_word_o = sys_word_q;
  assign gp_status_o          = gp_q;

endmodule

// file: tb/switch_bank.sv
// switch bank model: contacts wired to the seven input pins
`timescale 1ns/100ps
module switch_bank
(
  input  wire logic [6:0] closed_i,
  output logic      [6:0] pin_o
);
  // a closed contact pulls its pin high; bounce is not modelled
  assign pin_o = closed_i;
endmodule

// file: tb/input_status_reporting_properties.sv
// checker: port-level properties of the input status block
`timescale 1ns/100ps
module input_status_checker
(
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [6:0]  pin_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [11:0] system_signal_word_o,
  input wire logic [6:0]  gp_status_o
);
  logic wrote_q;
  logic wrote_d;
  // ----
  // defaults only hold until the first write after reset
  // ----
  always_comb wrote_d = !srst_i && (wrote_q || wr_i);
  always_ff @(posedge clk_i) wrote_q <= wrote_d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not cleared");
  a_word_read: assert property (rd_i && addr_i == 8'h00
    |=> rdata_o == {20'h0, system_signal_word_o}) else $error("word read");
  a_gp_read: assert property (rd_i && addr_i == 8'h04
    |=> rdata_o == {25'h0, gp_status_o}) else $error("gp flags read");
  a_single_read: assert property (rd_i && addr_i[7:5] == 3'h1
    && addr_i[1:0] == 2'h0 && addr_i[4:2] != 3'h7
    |=> rdata_o == {31'h0, gp_status_o[$past(addr_i[4:2])]})
    else $error("single flag read");
  a_unmapped_zero: assert property (rd_i && addr_i >= 8'h70
    |=> rdata_o == 32'h0) else $error("unmapped read not zero");
  a_reset_clear: assert property (disable iff (1'b0) srst_i
    |=> rdata_o == 32'h0 && system_signal_word_o == 12'h000
    && gp_status_o == 7'h00) else $error("reset values wrong");
  a_default_open: assert property (!wrote_q && !$past(srst_i)
    |-> gp_status_o == $past(pin_i) && system_signal_word_o == 12'h000)
    else $error("default level wrong");
  a_status_steady: assert property (!$past(srst_i) && !$past(wr_i)
    && $stable(pin_i) |=> $stable(gp_status_o)
    && $stable(system_signal_word_o)) else $error("status moved");
endmodule
bind input_status_reporting input_status_checker chk
(
  .clk_i(clk_i), .srst_i(srst_i), .pin_i(pin_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .system_signal_word_o(system_signal_word_o), .gp_status_o(gp_status_o)
);

// file: tb/input_status_reporting_tb.sv
// testbench: both status views read over the register port
`timescale 1ns/100ps
module input_status_reporting_tb;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        rd_seen = 1'b0;
  logic [6:0]  sw = 7'h00;
  logic [6:0]  pin;
  logic [6:0]  gp_lv;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic [11:0] sig_lv;
  logic [11:0] word_o;
  logic [6:0]  gp_o;
  logic [11:0] sig_en;
  logic [2:0]  sig_pin [12];
  logic [31:0] exp_q [$];
  int          seed = 32'h5053;
  int          n_mismatch = 0;
  int          comparisons = 0;
  switch_bank sw_bank (.closed_i(sw), .pin_o(pin));
  input_status_reporting dut
  (
    .clk_i(clk_i), .srst_i(srst_i), .pin_i(pin), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .system_signal_word_o(word_o), .gp_status_o(gp_o)
  );
  // ----
  // bench model and bus tasks
  // ----
  function automatic logic [11:0] exp_word(input logic [6:0] p);
    for (int s = 0; s < 12; s++)
      exp_word[s] = sig_en[s] & (p[sig_pin[s]] ^ sig_lv[s]);
  endfunction
  function automatic logic [6:0] exp_gp(input logic [6:0] p);
    exp_gp = p ^ gp_lv;
    for (int s = 0; s < 12; s++)
      if (sig_en[s]) exp_gp[sig_pin[s]] = 1'b0;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic probe;
    logic [6:0] r;
    logic [6:0] g;
    r = 7'($random(seed));
    sw <= r;
    g = exp_gp(r);
    bus(0, 8'h00, {20'h0, exp_word(r)});
    bus(0, 8'h04, {25'h0, g});
    for (int p = 0; p < 7; p++)
      bus(0, 8'(32'h20 + 4 * p), {31'h0, g[p]});
    check({20'h0, word_o}, {20'h0, exp_word(r)});
    check({25'h0, gp_o}, {25'h0, g});
  endtask
  task automatic clear_model;
    gp_lv = 7'h00;
    sig_lv = 12'h000;
    sig_en = 12'h000;
    foreach (sig_pin[s]) sig_pin[s] = 3'h0;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----
  // result monitor, clock, watchdog and sequence
  // ----
  always @(posedge clk_i)
  begin
    rd_seen <= rd_i;
    if (rd_seen)
      check(rdata_o, exp_q.size() ? exp_q.pop_front() : 32'hDEADBEEF);
  end
  initial forever #4 clk_i = ~clk_i;
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    clear_model();
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 2; i < 28; i++)
      if (i < 5 || i > 15) bus(0, 8'(4 * i), 32'h0);
    repeat (3) probe();
    gp_lv = 7'($random(seed));
    bus(1, 8'h08, {25'h0, gp_lv});
    bus(0, 8'h08, {25'h0, gp_lv});
    repeat (3) probe();
    for (int s = 0; s < 12; s++)
    begin
      sig_en = 12'h001 << s;
      sig_pin[s] = 3'(s % 7);
      sig_lv[s] = s[0];
      bus(1, 8'h10, {20'h0, sig_en});
      bus(1, 8'h0C, {20'h0, sig_lv});
      bus(1, 8'(32'h40 + 4 * s), {29'h0, sig_pin[s]});
      repeat (2) probe();
    end
    sig_lv = 12'($random(seed));
    sig_en = 12'hFFF;
    bus(1, 8'h0C, {20'h0, sig_lv});
    bus(1, 8'h10, {20'h0, sig_en});
    repeat (4) probe();
    bus(1, 8'h00, 32'hFFFFFFFF);
    bus(1, 8'h14, 32'hFFFFFFFF);
    bus(0, 8'h14, 32'h0);
    bus(0, 8'hFC, 32'h0);
    probe();
    srst_i <= 1'b1;
    clear_model();
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) probe();
    repeat (3) @(posedge clk_i);
    if (exp_q.size() != 0) n_mismatch++;
    print_verdict();
  end
endmodule
